//--- verilog/mrp_regs.svh
// constants for the metering serial register port host controller
// assumes a 100 MHz system clock and a device sampling on shift clock falls
//
// Functional notes
// [RQ1] device returns to command waiting after power-on, reset or select fall
// [RQ2] every transaction opens with one command byte from the host
// [RQ3] command byte is eight bits, five low bits address the register
// [RQ4] command msb of one marks a register write
// [RQ5] command msb of zero marks a register read
// [RQ6] device finishes once the register lsb has moved, then waits again
// [RQ7] device samples input data on shift clock falls; host sets data earlier
// [RQ8] device changes output on shift clock rises; host samples on falls
// [RQ9] select fall reinitialises the device port and discards partial state
// [RQ10] select stays low through a transaction; raising it aborts
// [RQ11] with select tied low every transfer runs to its last bit
// [RQ12] write data capture starts on the fall right after the command
// [RQ13] each write byte completes at least 4 us after the previous one
// [RQ14] a write byte cut short by select rising is not committed
// [RQ15] data is one to three bytes, msb first, right justified
// [RQ16] device drives its output from the rise after the command byte
// [RQ17] device floats its output on the last clock fall of a read
// [RQ18] device floats its output when select rises during a read
// [RQ19] device snapshots the whole register when addressed for a read
// [RQ20] host waits at least 4 us after a write before a read command
// [RQ21] bits go msb first; the two command bits above the address are zero
`ifndef MRP_REGS_SVH
`define MRP_REGS_SVH

// controller register offsets
`define MRP_OFS_COMMAND 8'h00
`define MRP_OFS_WDATA   8'h04
`define MRP_OFS_RDATA   8'h08
`define MRP_OFS_STATUS  8'h0C
`define MRP_OFS_CONTROL 8'h10

// command register fields
`define MRP_CMD_WR_BIT  7
`define MRP_CMD_ADDR_HI 4
`define MRP_CMD_LEN_HI  9
`define MRP_CMD_LEN_LO  8

// status and control fields
`define MRP_STS_BUSY    0
`define MRP_STS_DONE    1
`define MRP_STS_ABORT   2
`define MRP_CTL_ABORT   0

// timing
`define MRP_CLK_NS      10
`define MRP_GAP_NS      4000
`define MRP_GAP_CYC     ((`MRP_GAP_NS + `MRP_CLK_NS - 1) / `MRP_CLK_NS)
`define MRP_HALF_CYC    8

// bus answers
`define MRP_RESP_OKAY   2'h0
`define MRP_RESP_SLVERR 2'h2

`endif

//--- verilog/mrp_pkg.sv
// types for the metering serial register port host controller
// assumes nothing of its surroundings
`default_nettype none
package mrp_pkg;

  // transaction sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_SETUP = 5'h02,
    ST_SHIFT = 5'h04,
    ST_GAP   = 5'h08,
    ST_END   = 5'h10
  } mrp_state_e;

  typedef logic [31:0] mrp_word_t;

endpackage
`default_nettype wire

//--- verilog/mrp_tick_if.sv
// half-period tick carrier between sequencer and divider
// assumes both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface mrp_tick_if;
  logic run;
  logic tick;
  modport gen (input run, output tick);
  modport use_side (output run, input tick);
endinterface
`default_nettype wire

//--- verilog/mrp_tick_gen.sv
// divider giving one-cycle enables per shift clock half period
// assumes run drops between bursts so phase restarts cleanly
`timescale 1ns/10ps
`default_nettype none
`include "mrp_regs.svh"
module mrp_tick_gen (
  // clock and reset
  input  wire logic  clock,
  input  wire logic  reset,
  // tick carrier
  mrp_tick_if.gen    tk
);
  logic [3:0] cnt_ff;
  logic       tick_ff;
  wire        wrap = (cnt_ff == 4'(`MRP_HALF_CYC - 1));

  // count while running, restart when stopped
  always_ff @(posedge clock) begin
    if (reset || !tk.run) begin
      cnt_ff  <= 4'h0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= wrap ? 4'h0 : cnt_ff + 4'h1;
      tick_ff <= wrap;
    end
  end

  assign tk.tick = tick_ff;
endmodule // mrp_tick_gen
`default_nettype wire

//--- verilog/mrp_sync2.sv
// two-stage synchroniser for a pin input
// assumes the input is asynchronous to clock
`timescale 1ns/10ps
`default_nettype none
module mrp_sync2 (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // data
  input  wire logic async_in,
  output var  logic sync_out
);
  logic meta_ff;

  // first stage feeds only the second
  always_ff @(posedge clock) begin
    if (reset) begin
      meta_ff  <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // mrp_sync2
`default_nettype wire

//--- verilog/mrp_host.sv
// host controller for the metering serial register port
// assumes an axi4-lite master on the bus side and the device on the pins
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "mrp_regs.svh"
module mrp_host (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  // axi4-lite read data
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // device serial pins
  output var  logic        shift_clock,
  output var  logic        select_n,
  output var  logic        serial_in_pin,
  input  wire logic        serial_out_pin
);
  // properties sample on the system clock and sleep in reset
  default clocking ck_sys @(posedge clock); endclocking
  default disable iff (reset);

  // bus side state
  logic        aw_hold_ff;
  logic        w_hold_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wbus_ff;
  logic [3:0]  wstrb_ff;
  logic        awready_ff;
  logic        wready_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        arready_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;

  // controller registers
  logic [9:0]  cmd_ff;
  logic [23:0] wdat_ff;
  logic        done_ff;
  logic        aborted_ff;

  // sequencer state
  mrp_pkg::mrp_state_e st_ff;
  mrp_pkg::mrp_state_e nxt_st;
  logic [31:0] tx_ff;
  logic [31:0] nxt_tx;
  logic [23:0] rx_ff;
  logic [23:0] nxt_rx;
  logic [5:0]  bit_cnt_ff;
  logic [5:0]  nxt_bit_cnt;
  logic [5:0]  total_ff;
  logic [8:0]  gap_cnt_ff;
  logic [8:0]  nxt_gap_cnt;
  logic        wr_ff;
  logic        sclk_ff;
  logic        nxt_sclk;
  logic        csn_ff;
  logic        nxt_csn;
  logic        din_ff;
  logic        nxt_din;
  logic        dout_s;

  // divider and input synchroniser
  mrp_tick_if tk ();

  mrp_tick_gen u_tick (
    .clock (clock),
    .reset (reset),
    .tk    (tk.gen)
  );

  mrp_sync2 u_sync (
    .clock    (clock),
    .reset    (reset),
    .async_in (serial_out_pin),
    .sync_out (dout_s)
  );

  // write channel handshakes
  wire aw_take = s_axi_awvalid & awready_ff;
  wire w_take  = s_axi_wvalid & wready_ff;
  wire wr_go   = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  wire nxt_aw_hold = (aw_hold_ff | aw_take) & ~wr_go;
  wire nxt_w_hold  = (w_hold_ff | w_take) & ~wr_go;
  wire nxt_bvalid  = wr_go | (bvalid_ff & ~s_axi_bready);

  // read channel handshakes
  wire ar_take    = s_axi_arvalid & arready_ff;
  wire nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);

  // write address decode
  wire w_cmd = (awaddr_ff == `MRP_OFS_COMMAND);
  wire w_dat = (awaddr_ff == `MRP_OFS_WDATA);
  wire w_rdt = (awaddr_ff == `MRP_OFS_RDATA);
  wire w_sts = (awaddr_ff == `MRP_OFS_STATUS);
  wire w_ctl = (awaddr_ff == `MRP_OFS_CONTROL);
  wire w_ok  = w_cmd | w_dat | w_rdt | w_sts | w_ctl;

  // read address decode
  wire r_cmd = (s_axi_araddr == `MRP_OFS_COMMAND);
  wire r_dat = (s_axi_araddr == `MRP_OFS_WDATA);
  wire r_rdt = (s_axi_araddr == `MRP_OFS_RDATA);
  wire r_sts = (s_axi_araddr == `MRP_OFS_STATUS);
  wire r_ctl = (s_axi_araddr == `MRP_OFS_CONTROL);
  wire r_ok  = r_cmd | r_dat | r_rdt | r_sts | r_ctl;

  // register side effects of a bus write
  wire idle      = (st_ff == mrp_pkg::ST_IDLE);
  wire busy      = ~idle;
  wire start     = wr_go & w_cmd & idle & wstrb_ff[0];
  wire abort_req = wr_go & w_ctl & wstrb_ff[0] & wbus_ff[`MRP_CTL_ABORT];
  wire clr_done  = wr_go & w_sts & wstrb_ff[0] & wbus_ff[`MRP_STS_DONE];
  wire clr_abort = wr_go & w_sts & wstrb_ff[0] & wbus_ff[`MRP_STS_ABORT];

  // command word as loaded at start
  wire [9:0] ld_cmd = {wbus_ff[9:8], wstrb_ff[0] ? wbus_ff[7:0] : 8'h00};
  wire [1:0] ld_len = (ld_cmd[9:8] == 2'h0) ? 2'h1 : ld_cmd[9:8]; // RQ15
  wire [7:0] cmd8   = {ld_cmd[`MRP_CMD_WR_BIT], 2'b00,
                       ld_cmd[`MRP_CMD_ADDR_HI:0]}; // RQ3 RQ21
  wire [5:0] ld_total = {1'b0, ld_len, 3'b000} + 6'd8;

  // right-justified data placed behind the command byte
  wire [23:0] tx_data = (ld_len == 2'h1) ? {wdat_ff[7:0], 16'h0000} :
                        (ld_len == 2'h2) ? {wdat_ff[15:0], 8'h00} :
                        wdat_ff; // RQ15
  wire [31:0] tx_load = {cmd8, tx_data}; // RQ2

  // read data selection
  wire [31:0] rd_mux =
    r_cmd ? {22'h00_0000, cmd_ff} :
    r_dat ? {8'h00, wdat_ff} :
    r_rdt ? {8'h00, rx_ff} :
    r_sts ? {29'h0000_0000, aborted_ff, done_ff, busy} :
    32'h0000_0000;

  // sequencer helpers
  wire last_bit  = (bit_cnt_ff == total_ff);
  wire byte_edge = (bit_cnt_ff[2:0] == 3'h0);
  wire gap_over  = (gap_cnt_ff == 9'(`MRP_GAP_CYC - 1));
  wire data_ph   = (bit_cnt_ff >= 6'd8);
  assign tk.run  = st_ff inside {mrp_pkg::ST_SETUP, mrp_pkg::ST_SHIFT};

  // bus channel flops
  always_ff @(posedge clock) begin
    if (reset) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff  <= nxt_w_hold;
      awready_ff <= ~nxt_aw_hold & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_hold & ~nxt_bvalid;
      bvalid_ff  <= nxt_bvalid;
      arready_ff <= ~nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
    end
  end

  // bus payload capture
  always_ff @(posedge clock) begin
    if (reset) begin
      awaddr_ff <= 8'h00;
      wbus_ff   <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      bresp_ff  <= `MRP_RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `MRP_RESP_OKAY;
    end else begin
      if (aw_take) awaddr_ff <= s_axi_awaddr;
      if (w_take) wbus_ff <= s_axi_wdata;
      if (w_take) wstrb_ff <= s_axi_wstrb;
      if (wr_go) bresp_ff <= w_ok ? `MRP_RESP_OKAY : `MRP_RESP_SLVERR;
      if (ar_take) rdata_ff <= rd_mux;
      if (ar_take) rresp_ff <= r_ok ? `MRP_RESP_OKAY : `MRP_RESP_SLVERR;
    end
  end

  // write data register, one byte lane each
  for (genvar gi = 0; gi < 3; gi++) begin : g_wlane
    always_ff @(posedge clock) begin
      if (reset) begin
        wdat_ff[gi*8 +: 8] <= 8'h00;
      end else if (wr_go && w_dat && wstrb_ff[gi] && idle) begin
        wdat_ff[gi*8 +: 8] <= wbus_ff[gi*8 +: 8];
      end
    end
  end

  // command register and sticky flags, set wins over clear
  always_ff @(posedge clock) begin
    if (reset) begin
      cmd_ff     <= 10'h000;
      done_ff    <= 1'b0;
      aborted_ff <= 1'b0;
    end else begin
      if (start) cmd_ff <= ld_cmd;
      done_ff    <= (st_ff == mrp_pkg::ST_END) | (done_ff & ~clr_done);
      aborted_ff <= (abort_req & busy) | (aborted_ff & ~clr_abort);
    end
  end

  // sequencer next state
  always_comb begin
    nxt_st      = st_ff;
    nxt_tx      = tx_ff;
    nxt_rx      = rx_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_gap_cnt = 9'h000;
    nxt_sclk    = sclk_ff;
    nxt_csn     = csn_ff;
    nxt_din     = din_ff;
    unique case (st_ff)
      mrp_pkg::ST_IDLE: begin
        if (start) begin
          nxt_st      = mrp_pkg::ST_SETUP;
          nxt_csn     = 1'b0; // RQ10
          nxt_sclk    = 1'b1;
          nxt_tx      = tx_load;
          nxt_din     = tx_load[31]; // RQ21
          nxt_bit_cnt = 6'h00;
          nxt_rx      = 24'h00_0000;
        end
      end
      mrp_pkg::ST_SETUP: begin
        if (tk.tick) nxt_st = mrp_pkg::ST_SHIFT;
      end
      mrp_pkg::ST_SHIFT: begin
        if (tk.tick && sclk_ff) begin
          nxt_sclk    = 1'b0; // RQ7
          nxt_bit_cnt = bit_cnt_ff + 6'h01;
          if (!wr_ff && data_ph) nxt_rx = {rx_ff[22:0], dout_s}; // RQ8
        end else if (tk.tick) begin
          nxt_sclk = 1'b1;
          nxt_tx   = {tx_ff[30:0], 1'b0};
          nxt_din  = tx_ff[30];
          if (last_bit) begin
            nxt_st = wr_ff ? mrp_pkg::ST_GAP : mrp_pkg::ST_END; // RQ11
          end else if (wr_ff && byte_edge) begin
            nxt_st = mrp_pkg::ST_GAP; // RQ13
          end
        end
      end
      mrp_pkg::ST_GAP: begin
        nxt_gap_cnt = gap_cnt_ff + 9'h001;
        if (gap_over) begin
          nxt_st      = last_bit ? mrp_pkg::ST_END : mrp_pkg::ST_SHIFT;
          nxt_gap_cnt = 9'h000; // RQ20
        end
      end
      mrp_pkg::ST_END: begin
        nxt_st  = mrp_pkg::ST_IDLE;
        nxt_csn = 1'b1;
      end
    endcase
    if (abort_req && busy) begin
      nxt_st   = mrp_pkg::ST_IDLE;
      nxt_csn  = 1'b1; // RQ10
      nxt_sclk = 1'b1;
    end
  end

  // sequencer flops
  always_ff @(posedge clock) begin
    if (reset) begin
      st_ff      <= mrp_pkg::ST_IDLE;
      tx_ff      <= 32'h0000_0000;
      rx_ff      <= 24'h00_0000;
      bit_cnt_ff <= 6'h00;
      gap_cnt_ff <= 9'h000;
      sclk_ff    <= 1'b1;
      csn_ff     <= 1'b1;
      din_ff     <= 1'b0;
    end else begin
      st_ff      <= nxt_st;
      tx_ff      <= nxt_tx;
      rx_ff      <= nxt_rx;
      bit_cnt_ff <= nxt_bit_cnt;
      gap_cnt_ff <= nxt_gap_cnt;
      sclk_ff    <= nxt_sclk;
      csn_ff     <= nxt_csn;
      din_ff     <= nxt_din;
    end
  end

  // transfer shape latched at start
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ff    <= 1'b0;
      total_ff <= 6'h00;
    end else if (start) begin
      wr_ff    <= ld_cmd[`MRP_CMD_WR_BIT]; // RQ4 RQ5
      total_ff <= ld_total;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign shift_clock   = sclk_ff;
  assign select_n      = csn_ff;
  assign serial_in_pin = din_ff;

  // checks on the pin sequence
  AST_IDLE_CLK_HIGH: assert property (csn_ff |-> sclk_ff) // RQ10
    else $error("shift clock low while select high");
  AST_SEL_SETUP: assert property ($fell(csn_ff) |-> sclk_ff [*4]) // RQ2
    else $error("shift clock fell too soon after select");
  AST_DIN_STABLE: assert property ($fell(sclk_ff) |-> $stable(din_ff)) // RQ7
    else $error("data changed at the sampling edge");
  AST_CMD_WR_FLAG: assert property (start |=> tx_ff[31] == wr_ff) // RQ4
    else $error("command msb does not match direction");
  AST_CMD_ADDR: assert property ( // RQ3
    start |=> tx_ff[30:24] == {2'b00, cmd_ff[4:0]})
    else $error("command address field wrong");
  AST_RX_ON_FALL: assert property ( // RQ8
    $changed(rx_ff) |-> !sclk_ff || $past(st_ff) == mrp_pkg::ST_IDLE)
    else $error("read data taken off a falling edge");
  AST_FULL_XFER: assert property ( // RQ11
    st_ff == mrp_pkg::ST_END |-> bit_cnt_ff == total_ff)
    else $error("transfer ended before its last bit");
  AST_GAP_LEN: assert property ( // RQ13
    st_ff == mrp_pkg::ST_GAP && nxt_st != mrp_pkg::ST_GAP && !abort_req
    |-> gap_cnt_ff == 9'(`MRP_GAP_CYC - 1))
    else $error("write byte gap too short");
  AST_WR_TAIL: assert property ( // RQ20
    st_ff == mrp_pkg::ST_END && wr_ff |-> $past(st_ff) == mrp_pkg::ST_GAP)
    else $error("write ended without trailing gap");
  AST_ABORT: assert property (abort_req && busy |=> csn_ff && idle) // RQ10
    else $error("abort did not raise select");
  // main scenarios
  COV_READ: cover property (st_ff == mrp_pkg::ST_END && !wr_ff);
  COV_WRITE3: cover property (
    st_ff == mrp_pkg::ST_END && wr_ff && total_ff == 6'd32);
  COV_ABORT: cover property (abort_req && st_ff == mrp_pkg::ST_SHIFT);

endmodule // mrp_host
`default_nettype wire

//--- dv/mrp_dev_model.sv
// behavioural model of the metering device's serial register port
// assumes the host drives select, shift clock and data in; no pull on data out
`timescale 1ns/10ps
`default_nettype none
module mrp_dev_model (
  // device pins
  input  wire logic       shift_clock,
  input  wire logic       select_n,
  input  wire logic       serial_in_pin,
  output var  logic       serial_out_pin,
  // observation for the bench
  output var  logic [7:0] last_cmd,
  output var  int         viol_cnt
);
  logic [23:0] regs [32];
  logic [23:0] snap;
  logic [7:0]  sh;
  logic [4:0]  addr;
  logic        in_cmd;
  logic        rd;
  logic        drv;
  int          nbit;
  int          total;
  realtime     t_byte;
  realtime     t_wend;

  // register length in bytes by address band
  function automatic int len_of(input logic [4:0] a);
    return (a < 5'h08) ? 3 : ((a < 5'h10) ? 2 : 1);
  endfunction

  // power-on contents and command waiting
  initial begin
    foreach (regs[i]) regs[i] = 24'hC3_0000 | 24'(i);
    in_cmd = 1'b1;
    rd = 1'b0;
    drv = 1'b0;
    nbit = 0;
    total = 8;
    sh = 8'h00;
    last_cmd = 8'h00;
    viol_cnt = 0;
    serial_out_pin = 1'b0;
    t_byte = -1.0e9;
    t_wend = -1.0e9;
  end

  // select fall drops any partial state
  always @(negedge select_n) begin
    in_cmd = 1'b1;
    nbit = 0;
    rd = 1'b0;
  end

  // select rise aborts; output floats, partial byte never committed
  always @(posedge select_n) begin
    if (drv) begin
      drv = 1'b0;
      serial_out_pin = ~serial_out_pin;
    end
    in_cmd = 1'b0;
    nbit = 0;
  end

  // input bits taken on falls, msb first
  always @(negedge shift_clock) if (!select_n) begin
    sh = {sh[6:0], serial_in_pin};
    nbit++;
    if (in_cmd && nbit == 8) begin
      last_cmd = sh;
      addr = sh[4:0];
      rd = !sh[7];
      total = 8 * len_of(sh[4:0]);
      snap = regs[sh[4:0]];
      if (rd && ($realtime - t_wend) < 4000.0) viol_cnt++;
      t_byte = $realtime;
      in_cmd = 1'b0;
      nbit = 0;
    end else if (!in_cmd && rd && nbit == total) begin
      drv = 1'b0;
      serial_out_pin = ~serial_out_pin;
      in_cmd = 1'b1;
      nbit = 0;
    end else if (!in_cmd && !rd && nbit % 8 == 0) begin
      if (($realtime - t_byte) < 4000.0) viol_cnt++;
      regs[addr][(total - nbit) +: 8] = sh;
      t_byte = $realtime;
      if (nbit == total) begin
        in_cmd = 1'b1;
        nbit = 0;
        t_wend = $realtime;
      end
    end
  end

  // output bits change on rises, starting after the command byte
  always @(posedge shift_clock) if (!select_n && !in_cmd && rd) begin
    drv = 1'b1;
    serial_out_pin = snap[total - 1 - nbit];
  end
endmodule // mrp_dev_model
`default_nettype wire

//--- dv/metering_serial_register_port_test.sv
// self-checking bench for the serial register port host controller
// assumes the device model on the pins and an axi4-lite master here
`timescale 1ns/10ps
`default_nettype none
`include "mrp_regs.svh"
`define CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module metering_serial_register_port_test;
  typedef struct packed {
    logic        wr;
    logic [1:0]  len;
    logic [4:0]  addr;
    logic [23:0] data;
  } mrp_row_s;

  logic        clock;
  logic        reset;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        shift_clock;
  logic        select_n;
  logic        serial_in_pin;
  logic        serial_out_pin;
  logic [7:0]  last_cmd;
  int          viol_cnt;
  int          error_cnt;
  int          comparisons;
  int          cycles;
  logic [31:0] rd;
  logic [1:0]  rsp;

  // ordinary transfers: model contents start at c3_0000 plus address
  // the last row asks for zero bytes, which the controller sends as one
  mrp_row_s rows [9] = '{
    '{1'h0, 2'h3, 5'h03, 24'hC3_0003}, '{1'h1, 2'h3, 5'h05, 24'h12_3456},
    '{1'h0, 2'h3, 5'h05, 24'h12_3456}, '{1'h1, 2'h2, 5'h0A, 24'h00_0BCD},
    '{1'h0, 2'h2, 5'h0A, 24'h00_0BCD}, '{1'h1, 2'h1, 5'h1F, 24'h00_00A5},
    '{1'h0, 2'h1, 5'h1F, 24'h00_00A5}, '{1'h0, 2'h1, 5'h10, 24'h00_0010},
    '{1'h0, 2'h0, 5'h11, 24'h00_0011}};

  mrp_host dut (.clock, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .shift_clock, .select_n, .serial_in_pin,
    .serial_out_pin);

  mrp_dev_model model (.shift_clock, .select_n, .serial_in_pin,
    .serial_out_pin, .last_cmd, .viol_cnt);

  // verdict and end of run
  task automatic report_and_stop();
    $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one axi4-lite write, both channels offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clock);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // one axi4-lite read
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // poll status until the transfer is over
  task automatic wait_idle();
    logic [31:0] s;
    logic [1:0]  r;
    s = 32'h0000_0001;
    while (s[`MRP_STS_BUSY] !== 1'b0) axr(`MRP_OFS_STATUS, s, r);
  endtask

  // system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // main sequence
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_rready = 1'b0;
    reset = 1'b1;
    error_cnt = 0;
    comparisons = 0;
    cycles = 0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK({select_n, shift_clock, serial_in_pin}, 3'h6)
    axr(`MRP_OFS_STATUS, rd, rsp);
    `CHK(rd, 32'h0000_0000)
    foreach (rows[i]) begin
      axw(`MRP_OFS_WDATA, {8'h00, rows[i].data}, rsp);
      axw(`MRP_OFS_COMMAND,
          {22'h0, rows[i].len, rows[i].wr, 2'h0, rows[i].addr}, rsp);
      `CHK(rsp, `MRP_RESP_OKAY)
      wait_idle();
      `CHK(last_cmd, {rows[i].wr, 2'h0, rows[i].addr})
      axr(`MRP_OFS_STATUS, rd, rsp);
      `CHK(rd[2:0], 3'h2)
      axw(`MRP_OFS_STATUS, 32'h0000_0002, rsp);
      if (!rows[i].wr) begin
        axr(`MRP_OFS_RDATA, rd, rsp);
        `CHK(rd, {8'h00, rows[i].data})
        `CHK(rsp, `MRP_RESP_OKAY)
      end
    end
    // unmapped places answer with an error
    axr(8'h14, rd, rsp);
    `CHK({rsp, rd}, {`MRP_RESP_SLVERR, 32'h0000_0000})
    axw(8'h18, 32'h0000_0001, rsp);
    `CHK(rsp, `MRP_RESP_SLVERR)
    // abort a three-byte write in its second data byte
    axw(`MRP_OFS_WDATA, 32'h00FF_FFFF, rsp);
    axw(`MRP_OFS_COMMAND, 32'h0000_0386, rsp);
    repeat (1100) @(posedge clock);
    axw(`MRP_OFS_CONTROL, 32'h0000_0001, rsp);
    repeat (2) @(posedge clock);
    `CHK(select_n, 1'b1)
    axr(`MRP_OFS_STATUS, rd, rsp);
    `CHK(rd[2:0], 3'h4)
    axw(`MRP_OFS_STATUS, 32'h0000_0004, rsp);
    // reset in the middle of a read command leaves the pins idle
    axw(`MRP_OFS_COMMAND, 32'h0000_0103, rsp);
    repeat (100) @(posedge clock);
    reset <= 1'b1;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK({select_n, shift_clock, serial_in_pin}, 3'h6)
    axr(`MRP_OFS_STATUS, rd, rsp);
    `CHK(rd, 32'h0000_0000)
    repeat (400) @(posedge clock);
    axw(`MRP_OFS_COMMAND, 32'h0000_0306, rsp);
    wait_idle();
    axr(`MRP_OFS_RDATA, rd, rsp);
    `CHK(rd, 32'h00FF_0006)
    `CHK(viol_cnt, 0)
    report_and_stop();
  end
endmodule // metering_serial_register_port_test
`default_nettype wire
